/* File: include/rpc_pkg.sv */
// Shared constants, types and the level lookup function for the pattern controller
package rpc_pkg;

  // Clock and step timing
  localparam int CLK_HZ          = 20_000_000;
  localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
  // One duration code is worth this much time, in microseconds
  localparam int CET_STEP_US     = 196_667;
  localparam int CET_STEP_CYCLES = CET_STEP_US * CLK_PER_US;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PAT_CTRL = 6'h11;
  localparam logic [5:0] IDX_STATUS   = 6'h12;
  localparam logic [5:0] IDX_AUDIO2   = 6'h2b;
  localparam logic [1:0] IDX_CMD_TOP  = 2'h3;  // 0x30..0x3f

  // Sequencer control bits
  localparam int PAT_CURVE_BIT  = 0;
  localparam int PAT_REPEAT_BIT = 1;
  localparam int PAT_RUN_BIT    = 2;
  localparam logic [2:0] PAT_CTRL_RST = 3'h0;

  // Audio-follow control two fields
  localparam int AVG_BIT   = 4;
  localparam int MODE_LSB  = 2;
  localparam int SPEED_LSB = 0;
  localparam logic [4:0] AUDIO2_RST = 5'h00;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_STEP_LSB = 1;
  localparam int STAT_DONE_BIT = 4;

  // Command store shape: word A in the upper byte, word B in the lower
  localparam int CMD_STEPS = 8;
  localparam int STEP_AW   = 3;
  localparam int CMD_W     = 16;
  localparam int RED_LSB   = 13;
  localparam int GREEN_LSB = 10;
  localparam int CETHI_LSB = 8;
  localparam int CETLO_LSB = 6;
  localparam logic [CMD_W-1:0] CMD_RST = 16'h0000;
  localparam logic [STEP_AW-1:0] LAST_STEP = 3'h7;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} rpc_bus_e;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_FETCH, SEQ_LATCH, SEQ_RUN} rpc_seq_e;

  // Percent of peak drive current per three-bit level code
  function automatic logic [6:0] rpc_level_pct(input logic [2:0] code,
                                               input logic       curve);
    logic [6:0] pct;
    pct = 7'h00;
    unique case (code)
      3'h0: pct = 7'h00;
      3'h1: pct = curve ? 7'h01 : 7'h07;
      3'h2: pct = curve ? 7'h02 : 7'h0e;
      3'h3: pct = curve ? 7'h04 : 7'h15;
      3'h4: pct = curve ? 7'h0a : 7'h20;
      3'h5: pct = curve ? 7'h15 : 7'h2e;
      3'h6: pct = curve ? 7'h2e : 7'h47;
      3'h7: pct = 7'h64;
    endcase
    return pct;
  endfunction : rpc_level_pct

endpackage : rpc_pkg

/* File: include/rpc_mem_if.sv */
// Link between the controller and its command store
`timescale 1ns/1ps
`default_nettype none
interface rpc_mem_if;
  import rpc_pkg::*;
  logic                 ce;
  logic                 wrEn;
  logic [STEP_AW-1:0]   wrAddr;
  logic [1:0]           wrMask;
  logic [7:0]           wrData;
  logic [STEP_AW-1:0]   rdAddrA;
  logic [CMD_W-1:0]     rdDataA;
  logic [STEP_AW-1:0]   rdAddrB;
  logic [CMD_W-1:0]     rdDataB;
  modport ctrl (output ce, wrEn, wrAddr, wrMask, wrData, rdAddrA, rdAddrB,
                input rdDataA, rdDataB);
  modport mem  (input ce, wrEn, wrAddr, wrMask, wrData, rdAddrA, rdAddrB,
                output rdDataA, rdDataB);
endinterface : rpc_mem_if
`default_nettype wire

/* File: logic/rpc_cmd_mem.sv */
// Command step store, one write port and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module rpc_cmd_mem #(
  parameter int DEPTH = rpc_pkg::CMD_STEPS
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  rpc_mem_if.mem    port
);
  import rpc_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][CMD_W-1:0] cells;
    logic [CMD_W-1:0]            qa;
    logic [CMD_W-1:0]            qb;
  } rpc_mem_s;

  rpc_mem_s st;
  rpc_mem_s next_st;

  // Byte-masked write, both reads see the old contents
  always_comb begin
    next_st = st;
    if (port.ce) begin
      next_st.qa = st.cells[port.rdAddrA];
      next_st.qb = st.cells[port.rdAddrB];
      if (port.wrEn && port.wrMask[1])
        next_st.cells[port.wrAddr][15:8] = port.wrData;
      if (port.wrEn && port.wrMask[0])
        next_st.cells[port.wrAddr][7:0] = port.wrData;
    end
  end

  // All fields start at zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) st <= '0;
    else          st <= next_st;
  end

  assign port.rdDataA = st.qa;
  assign port.rdDataB = st.qb;

endmodule : rpc_cmd_mem
`default_nettype wire

/* File: logic/rpc_level_lut.sv */
// Level code to drive current percentage
`timescale 1ns/1ps
`default_nettype none
module rpc_level_lut (
  input  wire logic [2:0] code,
  input  wire logic       curve,
  output logic      [6:0] pct
);
  import rpc_pkg::*;

  // Pure table, registered by the caller
  always_comb begin
    pct = rpc_level_pct(code, curve);
  end

endmodule : rpc_level_lut
`default_nettype wire

/* File: logic/rpc_pattern_ctrl.sv */
// Red and green pattern command controller with audio-follow controls
//
// How it works
// - Red code in word A bits 7-5 maps to percent of peak current.
// - Green code in word A bits 4-2 uses the same two curves.
// - Averaging bit 4 of audio-follow control two enables averaging.
// - Bits 1-0 set response rate: fastest, fast, medium, slow.
// - Sequencer control bit 0 picks the intensity curve for all colours.
// - Run bit 2 low keeps sequencer idle; setting it starts at step zero.
// - Repeat bit 1 low plays once; high loops until stopped.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module rpc_pattern_ctrl #(
  parameter int unsigned STEP_CYCLES = rpc_pkg::CET_STEP_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEnable,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [6:0]  redLevel,
  output logic      [6:0]  greenLevel,
  output logic             averageEnable,
  output logic      [1:0]  filterMode,
  output logic      [1:0]  responseRate,
  output logic             patternActive,
  output logic      [2:0]  patternStep
);
  import rpc_pkg::*;

  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam logic [SW-1:0] PRE_LAST = SW'(STEP_CYCLES - 1);

  typedef struct packed {
    logic [2:0]         patCtrl;
    logic [4:0]         audio2;
    rpc_bus_e           busSt;
    logic [31:0]        rdData;
    rpc_seq_e           seqSt;
    logic [STEP_AW-1:0] step;
    logic [SW-1:0]      pre;
    logic [3:0]         units;
    logic [CMD_W-1:0]   cmd;
    logic [6:0]         red;
    logic [6:0]         green;
    logic               done;
  } rpc_state_s;

  rpc_state_s st;
  rpc_state_s next_st;

  rpc_mem_if memBus ();

  logic [5:0] idx;
  logic       hitCmd;
  logic       busWr;
  logic [3:0] cet;
  logic       preEnd;
  logic       stepEnd;
  logic [2:0] redCode;
  logic [2:0] greenCode;
  logic [6:0] redPct;
  logic [6:0] greenPct;

  // Word index decode; command words sit at 0x30..0x3f
  assign idx    = avs_address[7:2];
  assign hitCmd = (idx[5:4] == IDX_CMD_TOP);
  assign busWr  = avs_write && !avs_waitrequest && avs_byteenable[0];

  // Writes finish at once; reads take three edges for the store read
  assign avs_waitrequest = (avs_read || avs_write) &&
                           (!clkEnable || (avs_read && st.busSt != BUS_DONE));
  assign avs_readdata = st.rdData;

  // Store hookup; bus reads on port A, sequencer fetches on port B
  assign memBus.ce      = clkEnable;
  assign memBus.wrEn    = busWr && hitCmd;
  assign memBus.wrAddr  = idx[3:1];
  assign memBus.wrMask  = idx[0] ? 2'h1 : 2'h2;
  assign memBus.wrData  = avs_writedata[7:0];
  assign memBus.rdAddrA = idx[3:1];
  assign memBus.rdAddrB = st.step;

  rpc_cmd_mem #(
    .DEPTH (CMD_STEPS)
  ) u_store (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .port    (memBus.mem)
  );

  assign cet     = {st.cmd[CETHI_LSB +: 2], st.cmd[CETLO_LSB +: 2]};
  assign preEnd  = (st.pre == PRE_LAST);
  assign stepEnd = (st.seqSt == SEQ_RUN) && preEnd && (st.units == cet);

  // Codes are zero whenever no step is running, so the registered drivers go dark one edge later
  assign redCode   = (st.seqSt == SEQ_RUN) ? st.cmd[RED_LSB +: 3] : 3'h0;
  assign greenCode = (st.seqSt == SEQ_RUN) ? st.cmd[GREEN_LSB +: 3] : 3'h0;

  rpc_level_lut u_red (
    .code  (redCode),
    .curve (st.patCtrl[PAT_CURVE_BIT]),
    .pct   (redPct)
  );

  rpc_level_lut u_green (
    .code  (greenCode),
    .curve (st.patCtrl[PAT_CURVE_BIT]),
    .pct   (greenPct)
  );

  // Bus, register file and sequencer next state
  always_comb begin
    next_st = st;
    if (clkEnable) begin
      // Read path: accept, wait for store, answer
      unique case (st.busSt)
        BUS_IDLE: if (avs_read) next_st.busSt = BUS_WAIT;
        BUS_WAIT: begin
          next_st.busSt  = BUS_DONE;
          next_st.rdData = 32'h0000_0000;
          if (hitCmd)
            next_st.rdData[7:0] = idx[0] ? memBus.rdDataA[7:0]
                                         : memBus.rdDataA[15:8];
          else if (idx == IDX_PAT_CTRL)
            next_st.rdData[2:0] = st.patCtrl;
          else if (idx == IDX_AUDIO2)
            next_st.rdData[4:0] = st.audio2;
          else if (idx == IDX_STATUS) begin
            next_st.rdData[STAT_BUSY_BIT] = (st.seqSt != SEQ_IDLE);
            next_st.rdData[STAT_STEP_LSB +: 3] = st.step;
            next_st.rdData[STAT_DONE_BIT] = st.done;
          end
        end
        BUS_DONE: next_st.busSt = BUS_IDLE;
      endcase

      if (!st.patCtrl[PAT_RUN_BIT]) begin
        next_st.seqSt = SEQ_IDLE;
      end else begin
        unique case (st.seqSt)
          SEQ_IDLE: begin
            next_st.step  = '0;
            next_st.done  = 1'b0;
            next_st.seqSt = SEQ_FETCH;
          end
          SEQ_FETCH: next_st.seqSt = SEQ_LATCH;
          // Step words are latched so edits land on the next fetch
          SEQ_LATCH: begin
            next_st.cmd   = memBus.rdDataB;
            next_st.pre   = '0;
            next_st.units = 4'h0;
            next_st.seqSt = SEQ_RUN;
          end
          SEQ_RUN: begin
            // one prescaler wrap per code unit
            next_st.pre = st.pre + SW'(1);
            if (preEnd) begin
              next_st.pre   = '0;
              next_st.units = st.units + 4'h1;
            end
            if (stepEnd) begin
              next_st.seqSt = SEQ_FETCH;
              next_st.step  = st.step + 3'h1;
              // once or loop at last step
              if (st.step == LAST_STEP && !st.patCtrl[PAT_REPEAT_BIT]) begin
                next_st.seqSt               = SEQ_IDLE;
                next_st.done                = 1'b1;
                next_st.patCtrl[PAT_RUN_BIT] = 1'b0;
              end
            end
          end
        endcase
      end

      // Software writes last so a set of run beats the end-of-play clear
      if (busWr && idx == IDX_PAT_CTRL)
        next_st.patCtrl = avs_writedata[2:0];
      // averaging and rate held in audio-follow two
      if (busWr && idx == IDX_AUDIO2)
        next_st.audio2 = avs_writedata[4:0];

      next_st.red   = redPct;
      next_st.green = greenPct;
    end
  end

  // Single state register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st         <= '0;
      st.patCtrl <= PAT_CTRL_RST;
      st.audio2  <= AUDIO2_RST;
      st.cmd     <= CMD_RST;
      st.busSt   <= BUS_IDLE;
      st.seqSt   <= SEQ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign redLevel      = st.red;
  assign greenLevel    = st.green;
  assign averageEnable = st.audio2[AVG_BIT];
  assign filterMode    = st.audio2[MODE_LSB +: 2];
  assign responseRate  = st.audio2[SPEED_LSB +: 2];
  assign patternActive = (st.seqSt == SEQ_RUN);
  assign patternStep   = st.step;

  // red output follows latched code and curve
  property p_red_map;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && st.seqSt == SEQ_RUN) |=>
      redLevel == rpc_level_pct($past(st.cmd[15:13]), $past(st.patCtrl[0]));
  endproperty
  a_red_map: assert property (p_red_map)
    else $error("red level does not match code");

  property p_green_map;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && st.seqSt == SEQ_RUN) |=>
      greenLevel == rpc_level_pct($past(st.cmd[12:10]), $past(st.patCtrl[0]));
  endproperty
  a_green_map: assert property (p_green_map)
    else $error("green level does not match code");

  property p_avg_write;
    @(posedge ref_clk) disable iff (!reset_n)
    (busWr && idx == IDX_AUDIO2) |=> averageEnable == $past(avs_writedata[4]);
  endproperty
  a_avg_write: assert property (p_avg_write)
    else $error("averaging enable not updated");

  property p_rate_write;
    @(posedge ref_clk) disable iff (!reset_n)
    (busWr && idx == IDX_AUDIO2) |=>
      responseRate == $past(avs_writedata[1:0]);
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("response rate not updated");

  // a step ends only after its full code count
  property p_step_len;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && st.seqSt == SEQ_RUN && !stepEnd && st.patCtrl[2]) |=>
      st.step == $past(st.step) && st.seqSt == SEQ_RUN;
  endproperty
  a_step_len: assert property (p_step_len)
    else $error("step left before its duration");

  // curve one gives one percent for code one
  property p_curve_sel;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && st.seqSt == SEQ_RUN && st.cmd[15:13] == 3'h1 &&
     st.patCtrl[0]) |=> redLevel == 7'h01;
  endproperty
  a_curve_sel: assert property (p_curve_sel)
    else $error("curve select ignored");

  // start goes to the first step through a fetch
  property p_start;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && st.seqSt == SEQ_IDLE && st.patCtrl[2]) |=>
      st.step == 3'h0 && st.seqSt == SEQ_FETCH ##2 patternActive;
  endproperty
  a_start: assert property (p_start)
    else $error("sequence did not start at first step");

  // run low means idle next cycle
  property p_idle;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && !st.patCtrl[2]) |=> !patternActive;
  endproperty
  a_idle: assert property (p_idle)
    else $error("sequencer active with run low");

  // single play ends idle, looping wraps to step zero
  property p_play_end;
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEnable && stepEnd && st.step == 3'h7 && st.patCtrl[2]) |=>
      ($past(st.patCtrl[1]) ? (st.step == 3'h0 && st.seqSt == SEQ_FETCH)
                            : (st.seqSt == SEQ_IDLE && st.done));
  endproperty
  a_play_end: assert property (p_play_end)
    else $error("wrong action after last step");

endmodule : rpc_pattern_ctrl
`default_nettype wire

/* File: verif/rpc_pattern_ctrl_tb.sv */
// Self-checking bench for the pattern command controller
`timescale 1ns/1ps
`default_nettype none
module rpc_pattern_ctrl_tb;
  import rpc_pkg::*;
  // Short step unit keeps a full eight-step play to a few hundred cycles
  localparam int unsigned SC = 4;
  // Cycles of clock enable low laid into one step
  localparam int unsigned FREEZE = 5;
  logic        ref_clk;
  logic        reset_n;
  logic        clkEnable;
  logic [7:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [3:0]  avsByteenable;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [6:0]  redLevel;
  logic [6:0]  greenLevel;
  logic        averageEnable;
  logic [1:0]  filterMode;
  logic [1:0]  responseRate;
  logic        patternActive;
  logic [2:0]  patternStep;
  int          nErrors;
  int          compares;
  integer      seed;
  logic [31:0] d;
  logic [31:0] rdw;
  logic [3:0]  cetTab [8];
  logic [2:0]  redTab [8];
  logic [2:0]  grnTab [8];

  rpc_pattern_ctrl #(.STEP_CYCLES(SC)) rpc_pattern_ctrl_i (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .clkEnable       (clkEnable),
    .avs_address     (avsAddress),
    .avs_read        (avsRead),
    .avs_write       (avsWrite),
    .avs_writedata   (avsWritedata),
    .avs_byteenable  (avsByteenable),
    .avs_readdata    (avsReaddata),
    .avs_waitrequest (avsWaitrequest),
    .redLevel        (redLevel),
    .greenLevel      (greenLevel),
    .averageEnable   (averageEnable),
    .filterMode      (filterMode),
    .responseRate    (responseRate),
    .patternActive   (patternActive),
    .patternStep     (patternStep)
  );

  // Free-running 50 ns clock
  always #25 ref_clk = ~ref_clk;

  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  // Percent of peak drive per code, own copy of both curves
  function automatic logic [6:0] expPct(input logic [2:0] c,
                                        input logic       lg);
    logic [6:0] lin [8];
    logic [6:0] stp [8];
    lin = '{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64};
    stp = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64};
    return lg ? stp[c] : lin[c];
  endfunction : expPct

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One Avalon transfer, launched just after a rising edge; the edge
  // that sees waitrequest low also takes read data and ends it
  task automatic bus(input logic wr, input logic [7:0] addr,
                     input logic [7:0] data, input logic be0,
                     output logic [31:0] rd);
    int          n;
    logic [31:0] rnd;
    n = 0;
    rnd = $random(seed);
    // Own edge first, so callers may stand anywhere in the cycle
    @(posedge ref_clk);
    avsAddress    <= addr;
    avsWrite      <= wr;
    avsRead       <= !wr;
    avsWritedata  <= {rnd[31:8], data};
    avsByteenable <= {rnd[6:4], be0};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    if (avsWaitrequest !== 1'b0) begin
      nErrors++;
      $display("mismatch waitrequest expected 0 seen 1");
    end
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [7:0] addr, input logic [7:0] data);
    logic [31:0] rd;
    bus(1'b1, addr, data, 1'b1, rd);
  endtask : wreg

  task automatic rreg(input string what, input logic [7:0] addr,
                      input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, addr, 8'h00, 1'b1, rd);
    check(what, rd, exp);
  endtask : rreg

  // Load eight steps, start, and follow every step at the ports;
  // step three is held by clock enable low for a few cycles
  task automatic runSeq(input logic curve, input logic rpt);
    int          n;
    int          len;
    logic [31:0] r;
    for (int s = 0; s < CMD_STEPS; s++) begin
      r = $random(seed);
      // Red walks every code once on either curve
      redTab[s] = curve ? 3'(7 - s) : 3'(s);
      grnTab[s] = r[5:3];
      cetTab[s] = (s == 0) ? 4'h0 : (s == 7) ? 4'hf : r[9:6];
      wreg(ba(6'h30 + 6'(2 * s)), {redTab[s], grnTab[s], cetTab[s][3:2]});
      wreg(ba(6'h31 + 6'(2 * s)), {cetTab[s][1:0], r[15:10]});
    end
    repeat (6) @(negedge ref_clk);
    check("idle active", 32'(patternActive), 32'h0);
    check("idle red", 32'(redLevel), 32'h0);
    wreg(ba(IDX_PAT_CTRL), {5'h00, 1'b1, rpt, curve});
    for (int s = 0; s < 9; s++) begin
      n = 0;
      while (patternActive !== 1'b1 && n < 40) begin
        @(negedge ref_clk);
        n++;
      end
      check("step", 32'(patternStep), 32'(s % 8));
      @(negedge ref_clk);
      r = 32'(expPct(redTab[s % 8], curve));
      check("red", 32'(redLevel), r);
      r = 32'(expPct(grnTab[s % 8], curve));
      check("green", 32'(greenLevel), r);
      n = 1;
      // Clock enable low freezes the step timer as well
      if (s == 3) begin
        @(posedge ref_clk);
        clkEnable <= 1'b0;
        repeat (FREEZE) @(posedge ref_clk);
        clkEnable <= 1'b1;
        n += FREEZE;
      end
      do begin
        @(negedge ref_clk);
        n++;
      end while (patternActive === 1'b1 && n < 100);
      len = (cetTab[s % 8] + 1) * SC + ((s == 3) ? FREEZE : 0);
      check("length", 32'(n), 32'(len));
      if (s == 7 && !rpt) break;
    end
    if (!rpt) begin
      repeat (8) @(negedge ref_clk);
      check("after play", 32'(patternActive), 32'h0);
      rreg("run cleared", ba(IDX_PAT_CTRL), {30'h0, rpt, curve});
      bus(1'b0, ba(IDX_STATUS), 8'h00, 1'b1, r);
      check("done", 32'(r[STAT_DONE_BIT]), 32'h1);
      check("not busy", 32'(r[STAT_BUSY_BIT]), 32'h0);
    end else begin
      wreg(ba(IDX_PAT_CTRL), {6'h00, rpt, curve});
      // Idle one edge after the write edge, levels dark one edge later
      repeat (3) @(negedge ref_clk);
      check("stopped", 32'(patternActive), 32'h0);
      check("stopped red", 32'(redLevel), 32'h0);
    end
    $display("test sequence curve %0d loop %0d done", curve, rpt);
  endtask : runSeq

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Watchdog at 20000 cycles, several times what the tests need
  initial begin
    #1_000_000;
    nErrors++;
    $display("mismatch watchdog expected finish seen hang");
    end_of_test();
  end

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    clkEnable = 1'b1;
    avsAddress = 8'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    avsByteenable = 4'h0;
    nErrors = 0;
    compares = 0;
    seed = 32'ha472;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rreg("audio2 reset", ba(IDX_AUDIO2), 32'h0);
    check("avg reset", 32'(averageEnable), 32'h0);
    check("rate reset", 32'(responseRate), 32'h0);
    rreg("ctrl reset", ba(IDX_PAT_CTRL), 32'h0);
    rreg("word a reset", ba(6'h30), 32'h0);
    $display("test reset done");
    // every rate code, then random fills
    for (int i = 0; i < 12; i++) begin
      d = $random(seed);
      if (i < 4) d[1:0] = 2'(i);
      wreg(ba(IDX_AUDIO2), d[7:0]);
      rreg("audio2", ba(IDX_AUDIO2), {27'h0, d[4:0]});
      check("avg", 32'(averageEnable), 32'(d[4]));
      check("mode", 32'(filterMode), 32'(d[3:2]));
      check("rate", 32'(responseRate), 32'(d[1:0]));
    end
    // Lane zero disabled and unmapped places leave state alone
    bus(1'b1, ba(IDX_AUDIO2), ~d[7:0], 1'b0, rdw);
    rreg("no lane write", ba(IDX_AUDIO2), {27'h0, d[4:0]});
    check("no lane rate", 32'(responseRate), 32'(d[1:0]));
    wreg(ba(6'h05), 8'hff);
    rreg("unmapped", ba(6'h05), 32'h0);
    $display("test audio controls done");
    runSeq(1'b0, 1'b0);
    runSeq(1'b1, 1'b1);
    end_of_test();
  end
endmodule : rpc_pattern_ctrl_tb
`default_nettype wire
